// ==== mns_checksum.v ====
// Running LIN checksum accumulator with carry wrap
`timescale 1ns/1ps
`default_nettype none
module mns_checksum (
    input wire clk_sys,
    input wire rst_n,
    input wire clear,
    input wire add,
    input wire [7:0] data,
    output reg [7:0] sum,
    output wire [7:0] next_sum
);
    wire [8:0] raw_sum;
    wire [8:0] wrap_sum;

    assign raw_sum = {1'h0, sum} + {1'h0, data};
    // Carry folds back in, so one wrap can never carry again
    assign wrap_sum = {1'h0, raw_sum[7:0]} + {8'h00, raw_sum[8]};
    assign next_sum = wrap_sum[7:0];

    always @(posedge clk_sys) begin
        if (!rst_n || clear) begin
            sum <= 8'h00;
        end else if (add) begin
            sum <= next_sum;
        end
    end
endmodule // mns_checksum
`default_nettype wire

// ==== mns_cmd_node.v ====
// Command decoder of the stepper node: trim read, status read, safe move, halt
`timescale 1ns/1ps
`default_nettype none
`include "mns_consts.vh"
module mns_cmd_node #(
    parameter TARGET_W = 11,
    parameter POS_W = 16
) (
    input wire clk_sys,
    input wire rst_n,
    input wire frame_start,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    output wire tx_valid,
    output wire tx_last,
    output reg [7:0] tx_byte,
    input wire tx_ready,
    input wire [5:0] status_id,
    input wire [5:0] cmd_id,
    input wire [6:0] node_addr,
    input wire external_switch,
    input wire [2:0] addr_pin_state,
    input wire thermal_warning,
    input wire overtemp_shutdown,
    input wire undervolt,
    input wire coil_fault,
    input wire [1:0] temp_level,
    input wire [3:0] clock_trim,
    input wire [3:0] current_ref_trim,
    input wire [2:0] overtemp_trim,
    input wire [3:0] bandgap_trim,
    input wire address_mode_sel,
    input wire [3:0] phys_addr_bits,
    input wire [3:0] run_current,
    input wire [3:0] hold_current,
    input wire [3:0] speed_max,
    input wire [3:0] speed_min,
    input wire direction,
    input wire [3:0] ramp_rate,
    input wire [TARGET_W-1:0] safe_target,
    input wire [1:0] microstep_resolution,
    input wire trim_lock,
    input wire bandgap_lock,
    input wire bus_lost,
    input wire init_done,
    input wire sleep_request,
    input wire safe_move_suppress,
    input wire motor_moving,
    input wire [POS_W-1:0] current_location,
    input wire goal_load,
    input wire [POS_W-1:0] goal_value,
    output reg [POS_W-1:0] goal_location,
    output reg move_to_safe_target,
    output reg [TARGET_W-1:0] safe_target_out,
    output reg halt_request,
    output reg shutdown_mode,
    output reg trim_prepared,
    output wire supply_reset_flag,
    output wire missed_step_flag,
    output wire coil_fault_flag,
    output wire undervolt_flag,
    output wire overtemp_flag,
    output wire thermal_warning_flag
);
    localparam S_IDLE = 3'h0;
    localparam S_ID = 3'h1;
    localparam S_RXD = 3'h2;
    localparam S_RXC = 3'h3;
    localparam S_TX = 3'h4;
    localparam K_DIAG = 2'h0;
    localparam K_CMD = 2'h1;
    localparam K_STAT = 2'h2;
    localparam K_TRIM = 2'h3;
    // Flag vector order: tw, tsd, uv, coil, step, supply
    localparam F_TW = 0;
    localparam F_TSD = 1;
    localparam F_UV = 2;
    localparam F_COIL = 3;
    localparam F_STEP = 4;
    localparam F_SUP = 5;
    reg [2:0] state;
    reg [1:0] kind;
    reg [3:0] cnt;
    reg [3:0] len;
    reg [7:0] rx_buf [0:7];
    reg [5:0] flags;
    reg [5:0] next_flags;
    reg [7:0] pin_meta;
    reg [7:0] pin_sync;
    reg coil_prev;
    reg halt_pending;
    reg clear_status;
    wire chk_add;
    wire [7:0] chk_data;
    wire [7:0] chk_sum;
    wire [7:0] chk_next;
    wire [3:0] cnt_inc;
    wire rx_exec;
    wire tx_take;
    wire internal_halt;
    wire cmd_safe_move;
    wire cmd_halt;
    wire auto_safe_move;
    wire prep_frame;
    // Pins and analog comparator levels cross into the clock domain here
    wire esw_s = pin_sync[0];
    wire tw_s = pin_sync[1];
    wire tsd_s = pin_sync[2];
    wire uv_s = pin_sync[3];
    wire coil_s = pin_sync[4];
    wire [2:0] pins_s = pin_sync[7:5];
    function id_parity_ok;
        input [7:0] id;
        begin
            id_parity_ok = (id[6] == (id[0] ^ id[1] ^ id[2] ^ id[4])) &&
                           (id[7] == ~(id[1] ^ id[3] ^ id[4] ^ id[5]));
        end
    endfunction
    // Second data byte: active-low broadcast and node address
    function addr_hit;
        input [7:0] ab;
        input [6:0] own;
        begin
            addr_hit = !ab[`MNS_BCAST_BIT] || (ab[6:0] == own);
        end
    endfunction
    function [7:0] resp_byte;
        input [1:0] k;
        input [3:0] idx;
        begin
            resp_byte = 8'h00;
            if (k == K_STAT) begin
                case (idx)
                    4'h0: resp_byte = {esw_s, node_addr};
                    4'h1: resp_byte = {flags[F_SUP], flags[F_STEP], flags[F_COIL], flags[F_UV],
                                       flags[F_TSD], flags[F_TW], temp_level};
                    default: resp_byte = 8'h00;
                endcase
            end else begin
                case (idx)
                    4'h0: resp_byte = {clock_trim, current_ref_trim};
                    4'h1: resp_byte = {1'h1, overtemp_trim, bandgap_trim};
                    4'h2: resp_byte = {address_mode_sel, pins_s, phys_addr_bits};
                    4'h3: resp_byte = {run_current, hold_current};
                    4'h4: resp_byte = {speed_max, speed_min};
                    4'h5: resp_byte = {safe_target[10:8], direction, ramp_rate};
                    4'h6: resp_byte = safe_target[7:0];
                    4'h7: resp_byte = {4'h0, microstep_resolution, trim_lock, bandgap_lock};
                    default: resp_byte = 8'h00;
                endcase
            end
        end
    endfunction
    mns_checksum u_chk (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clear(frame_start),
        .add(chk_add),
        .data(chk_data),
        .sum(chk_sum),
        .next_sum(chk_next)
    );
    assign cnt_inc = cnt + 4'h1;
    assign tx_valid = (state == S_TX);
    assign tx_last = tx_valid && (cnt == len);
    assign tx_take = tx_valid && tx_ready;
    assign chk_add = ((state == S_RXD) && rx_valid && !frame_start) || (tx_take && (cnt != len));
    assign chk_data = (state == S_TX) ? tx_byte : rx_byte;
    // Frame executes only on matching checksum
    assign rx_exec = (state == S_RXC) && rx_valid && !frame_start && (rx_byte == ~chk_sum);
    assign prep_frame = (rx_buf[0] == `MNS_APP_CMD) &&
                        (rx_buf[1] == {1'h1, `MNS_CMD_TRIM_READ}) &&
                        (rx_buf[2] == {1'h1, node_addr}) &&
                        (rx_buf[3] == `MNS_FILL) && (rx_buf[4] == `MNS_FILL) &&
                        (rx_buf[5] == `MNS_FILL) && (rx_buf[6] == `MNS_FILL) &&
                        (rx_buf[7] == `MNS_FILL);
    // Command decoded from the data, only on frames with identifier cmd_id
    assign cmd_safe_move = rx_exec && (kind == K_CMD) &&
                           (rx_buf[0] == {1'h1, `MNS_CMD_SAFE_MOVE}) &&
                           addr_hit(rx_buf[1], node_addr);
    assign cmd_halt = rx_exec && (kind == K_CMD) &&
                      (rx_buf[0] == {1'h1, `MNS_CMD_HALT}) &&
                      addr_hit(rx_buf[1], node_addr);
    assign auto_safe_move = (bus_lost || init_done || sleep_request) && !safe_move_suppress;
    assign internal_halt = coil_s && !coil_prev;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
            coil_prev <= 1'h0;
        end else begin
            pin_meta <= {addr_pin_state, coil_fault, undervolt, overtemp_shutdown,
                         thermal_warning, external_switch};
            pin_sync <= pin_meta;
            coil_prev <= coil_s;
        end
    end
    // Frame sequencer
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= S_IDLE;
            kind <= K_DIAG;
            cnt <= 4'h0;
            len <= 4'h0;
            tx_byte <= 8'h00;
            clear_status <= 1'h0;
            trim_prepared <= 1'h0;
        end else begin
            clear_status <= 1'h0;
            if (frame_start) begin
                state <= S_ID;
                cnt <= 4'h0;
            end else begin
                case (state)
                    S_ID: begin
                        if (rx_valid) begin
                            cnt <= 4'h0;
                            state <= S_IDLE;
                            if (id_parity_ok(rx_byte)) begin
                                if (rx_byte[5:0] == `MNS_ID_DIAG_REQ) begin
                                    kind <= K_DIAG;
                                    len <= `MNS_DIAG_LEN;
                                    state <= S_RXD;
                                end else if (rx_byte[5:0] == `MNS_ID_DIAG_RESP) begin
                                    if (trim_prepared) begin
                                        kind <= K_TRIM;
                                        len <= `MNS_TRIM_LEN;
                                        tx_byte <= resp_byte(K_TRIM, 4'h0);
                                        state <= S_TX;
                                    end
                                end else if (rx_byte[5:0] == status_id) begin
                                    kind <= K_STAT;
                                    len <= `MNS_STAT_LEN;
                                    tx_byte <= resp_byte(K_STAT, 4'h0);
                                    state <= S_TX;
                                end else if (rx_byte[5:0] == cmd_id) begin
                                    kind <= K_CMD;
                                    len <= `MNS_WR_LEN;
                                    state <= S_RXD;
                                end
                            end
                        end
                    end
                    S_RXD: begin
                        if (rx_valid) begin
                            cnt <= cnt_inc;
                            if (cnt_inc == len) begin
                                state <= S_RXC;
                            end
                        end
                    end
                    S_RXC: begin
                        if (rx_valid) begin
                            state <= S_IDLE;
                            if (rx_exec && (kind == K_DIAG)) begin
                                trim_prepared <= prep_frame;
                            end
                        end
                    end
                    S_TX: begin
                        if (tx_ready) begin
                            if (cnt == len) begin
                                state <= S_IDLE;
                                clear_status <= (kind == K_STAT);
                                if (kind == K_TRIM) begin
                                    trim_prepared <= 1'h0;
                                end
                            end else begin
                                cnt <= cnt_inc;
                                // Checksum closes the answer after the last data byte
                                tx_byte <= (cnt_inc == len) ? ~chk_next : resp_byte(kind, cnt_inc);
                            end
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end
    always @(posedge clk_sys) begin
        if (state == S_RXD && rx_valid && !frame_start) begin
            rx_buf[cnt[2:0]] <= rx_byte;
        end
    end
    // Sticky flags; a live cause re-sets in the clearing cycle, so set wins
    always @* begin
        next_flags = flags & {6{~clear_status}};
        next_flags[F_TW] = next_flags[F_TW] | tw_s;
        next_flags[F_TSD] = next_flags[F_TSD] | tsd_s;
        next_flags[F_UV] = next_flags[F_UV] | uv_s;
        next_flags[F_COIL] = next_flags[F_COIL] | coil_s;
        next_flags[F_STEP] = next_flags[F_STEP] | (internal_halt && motor_moving);
    end
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            flags <= {`MNS_SUPPLY_RESET_RST, 5'h00};
        end else begin
            flags <= next_flags;
        end
    end
    assign thermal_warning_flag = flags[F_TW];
    assign overtemp_flag = flags[F_TSD];
    assign undervolt_flag = flags[F_UV];
    assign coil_fault_flag = flags[F_COIL];
    assign missed_step_flag = flags[F_STEP];
    assign supply_reset_flag = flags[F_SUP];
    // Motion side effects
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            move_to_safe_target <= 1'h0;
            safe_target_out <= {TARGET_W{1'b0}};
            halt_request <= 1'h0;
            halt_pending <= 1'h0;
            shutdown_mode <= 1'h0;
            goal_location <= {POS_W{1'b0}};
        end else begin
            move_to_safe_target <= cmd_safe_move || auto_safe_move;
            safe_target_out <= safe_target;
            halt_request <= cmd_halt || internal_halt;
            shutdown_mode <= shutdown_mode || internal_halt;
            if (cmd_halt || internal_halt) begin
                halt_pending <= 1'h1;
            end else if (halt_pending && !motor_moving && !halt_request) begin
                halt_pending <= 1'h0;
            end
            // Copy only once at rest, else the goal would trail a coasting motor
            if (halt_pending && !motor_moving && !halt_request) begin
                goal_location <= current_location;
            end else if (goal_load) begin
                goal_location <= goal_value;
            end
        end
    end
endmodule // mns_cmd_node
`default_nettype wire

// ==== mns_cmd_node_properties.sv ====
// Port-level checks of the motor node command decoder
`timescale 1ns/1ps
`default_nettype none
module mns_cmd_node_properties #(
    parameter TARGET_W = 11,
    parameter POS_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic frame_start,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic [7:0] tx_byte,
    input wire logic coil_fault,
    input wire logic motor_moving,
    input wire logic goal_load,
    input wire logic [POS_W-1:0] current_location,
    input wire logic [POS_W-1:0] goal_location,
    input wire logic [TARGET_W-1:0] safe_target,
    input wire logic [TARGET_W-1:0] safe_target_out,
    input wire logic move_to_safe_target,
    input wire logic halt_request,
    input wire logic shutdown_mode,
    input wire logic missed_step_flag,
    input wire logic bus_lost,
    input wire logic init_done,
    input wire logic sleep_request,
    input wire logic safe_move_suppress
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [3:0] tx_n;
    // Data bytes handed over so far in the current answer
    always @(posedge clk_sys) begin
        if (!rst_n || frame_start || (tx_valid && tx_ready && tx_last))
            tx_n <= 4'h0;
        else if (tx_valid && tx_ready)
            tx_n <= tx_n + 4'h1;
    end
    sequence s_halt_rest;
        halt_request ##1 (!motor_moving && !halt_request && !goal_load);
    endsequence
    sequence s_coil_halt;
        ##[2:5] halt_request ##[0:1] shutdown_mode;
    endsequence
    property p_stop_copy;
        s_halt_rest |=> goal_location == $past(current_location);
    endproperty
    property p_coil_halt;
        $rose(coil_fault) |-> s_coil_halt;
    endproperty
    property p_shut_sticky;
        shutdown_mode |=> shutdown_mode;
    endproperty
    property p_missed_cause;
        $rose(missed_step_flag) |-> $past(motor_moving);
    endproperty
    property p_move_pulse;
        move_to_safe_target |=> !move_to_safe_target;
    endproperty
    property p_halt_pulse;
        halt_request |=> !halt_request;
    endproperty
    property p_target;
        move_to_safe_target |-> safe_target_out == safe_target;
    endproperty
    property p_trigger;
        (bus_lost || init_done || sleep_request) && !safe_move_suppress |-> ##[1:2] move_to_safe_target;
    endproperty
    property p_tx_hold;
        tx_valid && !tx_ready && !frame_start |=> tx_valid && $stable(tx_byte);
    endproperty
    property p_tx_len;
        tx_valid && tx_ready && tx_last |-> tx_n == 4'h2 || tx_n == 4'h8;
    endproperty
    a_stop_copy: assert property (p_stop_copy) else $error("goal not loaded from location");
    a_coil_halt: assert property (p_coil_halt) else $error("coil fault gave no halt");
    a_shut_sticky: assert property (p_shut_sticky) else $error("shutdown dropped");
    a_missed_cause: assert property (p_missed_cause) else $error("missed step while idle");
    a_move_pulse: assert property (p_move_pulse) else $error("move pulse too long");
    a_halt_pulse: assert property (p_halt_pulse) else $error("halt pulse too long");
    a_target: assert property (p_target) else $error("wrong safe target");
    a_trigger: assert property (p_trigger) else $error("internal trigger lost");
    a_tx_hold: assert property (p_tx_hold) else $error("answer byte changed unsent");
    a_tx_len: assert property (p_tx_len) else $error("answer length wrong");
endmodule // mns_cmd_node_properties
`default_nettype wire

// ==== mns_consts.vh ====
// Shared constants of the motor node command decoder
// How it works
// - Preparing frame: 0x3C, 80, 0x82, address, FF
// - Trim response packs eight fixed data bytes
// - Address pin bits come live from pins
// - Status read clears sticky fault flags
// - Status answer is two bytes plus checksum
// - Status byte layout: switch, address, flags
// - Identifier top bits are checked parity
// - Safe move frame: command 0x84, broadcast, address
// - Broadcast zero moves every node to target
// - Internal triggers also start safe move
// - Two-byte commands decoded only on the command identifier
// - Coil fault triggers halt and shutdown
// - Coil-fault halt while moving sets missed-step flag
// - After halt, goal takes current location
// - Halt frame: command 0x85, broadcast, address
// - Trim answer goes on identifier 0x3D
`ifndef MNS_CONSTS_VH
`define MNS_CONSTS_VH
`define MNS_ID_DIAG_REQ 6'h3C
`define MNS_ID_DIAG_RESP 6'h3D
`define MNS_APP_CMD 8'h80
`define MNS_CMD_TRIM_READ 7'h02
`define MNS_CMD_SAFE_MOVE 7'h04
`define MNS_CMD_HALT 7'h05
`define MNS_FILL 8'hFF
`define MNS_DIAG_LEN 4'h8
`define MNS_WR_LEN 4'h2
`define MNS_STAT_LEN 4'h2
`define MNS_TRIM_LEN 4'h8
`define MNS_CMD_FLAG_BIT 7
`define MNS_BCAST_BIT 7
`define MNS_SUPPLY_RESET_RST 1'h1
`endif

// ==== mns_lin_master.sv ====
// Behavioural bus master feeding and draining the node byte link
`timescale 1ns/1ps
`default_nettype none
module mns_lin_master (
    input wire logic clk_sys,
    output logic frame_start,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic [7:0] tx_byte,
    output logic tx_ready
);
    logic [7:0] resp [0:9];
    int resp_n;
    initial begin
        frame_start = 1'h0;
        rx_valid = 1'h0;
        rx_byte = 8'h00;
        tx_ready = 1'h0;
    end
    function automatic [7:0] prot(input [5:0] id);
        return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction
    task automatic put(input [7:0] b, input v);
        @(posedge clk_sys);
        frame_start <= 1'h0;
        rx_valid <= v;
        rx_byte <= v ? b : ~rx_byte;
    endtask
    task automatic head(input [5:0] id, input [7:0] pf);
        @(posedge clk_sys);
        frame_start <= 1'h1;
        put(prot(id) ^ pf, 1'h1);
    endtask
    task automatic send(input [5:0] id, input int n, input [63:0] d, input [7:0] pf, input [7:0] cs);
        head(id, pf);
        for (int i = 0; i < n; i++) put(d[63 - 8 * i -: 8], 1'h1);
        put(cs, 1'h1);
        put(8'h00, 1'h0);
    endtask
    task automatic read(input [5:0] id);
        resp_n = 0;
        head(id, 8'h00);
        put(8'h00, 1'h0);
        for (int k = 0; k < 48; k++) begin
            @(posedge clk_sys);
            if (tx_valid && tx_ready && resp_n < 10) begin
                resp[resp_n] = tx_byte;
                resp_n++;
                if (tx_last) begin
                    tx_ready <= 1'h0;
                    break;
                end
            end
            rx_byte <= ~rx_byte;
            // Stall now and then so held bytes are exercised
            tx_ready <= k % 3 != 0 && k < 47;
        end
    endtask
endmodule // mns_lin_master
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench of the motor node command decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys, rst_n = 1'h0, frame_start, rx_valid, tx_valid, tx_last, tx_ready;
    logic [7:0] rx_byte, tx_byte;
    logic [5:0] status_id, cmd_id;
    logic [6:0] node_addr;
    logic external_switch = 1'h0, thermal_warning = 1'h0, overtemp_shutdown = 1'h0, undervolt = 1'h0;
    logic coil_fault = 1'h0, address_mode_sel, direction, trim_lock, bandgap_lock;
    logic [2:0] addr_pin_state = 3'h0, overtemp_trim;
    logic [1:0] temp_level = 2'h0, microstep_resolution;
    logic [3:0] clock_trim, current_ref_trim, bandgap_trim, phys_addr_bits, run_current, hold_current;
    logic [3:0] speed_max, speed_min, ramp_rate;
    logic [10:0] safe_target, safe_target_out;
    logic bus_lost = 1'h0, init_done = 1'h0, sleep_request = 1'h0, safe_move_suppress = 1'h0;
    logic motor_moving = 1'h0, goal_load = 1'h0;
    logic [15:0] current_location = 16'h0000, goal_value = 16'h0000, goal_location;
    logic move_to_safe_target, halt_request, shutdown_mode, trim_prepared, supply_reset_flag;
    logic missed_step_flag, coil_fault_flag, undervolt_flag, overtemp_flag, thermal_warning_flag;
    int fail_count = 0, tests_run = 0, seed = 32'h3b5a_d1fc, mv_n = 0, hl_n = 0, m0, h0;
    logic [63:0] r;
    mns_cmd_node mns_cmd_node_i (.*);
    mns_lin_master mns_lin_master_i (.*);
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        mv_n <= mv_n + int'(move_to_safe_target);
        hl_n <= hl_n + int'(halt_request);
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic [7:0] csum(input [63:0] d, input int n);
        logic [8:0] s;
        s = 9'h000;
        for (int i = 0; i < n; i++) begin
            s = s[7:0] + d[63 - 8 * i -: 8];
            s = s[7:0] + s[8];
        end
        return ~s[7:0];
    endfunction
    function automatic [63:0] trim_exp;
        return {clock_trim, current_ref_trim, 1'h1, overtemp_trim, bandgap_trim, address_mode_sel, addr_pin_state,
            phys_addr_bits, run_current, hold_current, speed_max, speed_min, safe_target[10:8], direction,
            ramp_rate, safe_target[7:0], 4'h0, microstep_resolution, trim_lock, bandgap_lock};
    endfunction
    task automatic resp_chk(input [63:0] d, input int n);
        check(16'(mns_lin_master_i.resp_n), 16'(n + 1));
        for (int i = 0; i < n; i++) check(16'(mns_lin_master_i.resp[i]), 16'(d[63 - 8 * i -: 8]));
        check(16'(mns_lin_master_i.resp[n]), 16'(csum(d, n)));
    endtask
    task automatic stat(input [7:0] b1);
        mns_lin_master_i.read(status_id);
        resp_chk({external_switch, node_addr, b1, 48'h0}, 2);
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic prep(input [6:0] a);
        r = {8'h80, 8'h82, 1'h1, a, 40'hff_ffff_ffff};
        mns_lin_master_i.send(6'h3c, 8, r, 8'h00, csum(r, 8));
        @(posedge clk_sys);
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        fail_count++;
        complete_run;
    end
    initial begin
        r = {$random(seed), $random(seed)};
        {clock_trim, current_ref_trim, overtemp_trim, bandgap_trim, address_mode_sel, phys_addr_bits, run_current,
            hold_current, speed_max, speed_min, direction, ramp_rate, safe_target, microstep_resolution,
            trim_lock, bandgap_lock} = r[55:0];
        node_addr = r[62:56];
        status_id = 6'(r[3:0]) | 6'h10;
        cmd_id = 6'(r[7:4]) | 6'h20;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk_sys);
        check(16'({supply_reset_flag, missed_step_flag, shutdown_mode, trim_prepared}), 16'h0008);
        stat({1'h1, 5'h00, temp_level});
        check(16'(supply_reset_flag), 16'h0000);
        {thermal_warning, overtemp_shutdown, undervolt} <= 3'h7;
        repeat (4) @(posedge clk_sys);
        {thermal_warning, overtemp_shutdown} <= 2'h0;
        repeat (4) @(posedge clk_sys);
        stat({3'h0, 3'h7, temp_level});
        check(16'({undervolt_flag, overtemp_flag, thermal_warning_flag}), 16'h0004);
        undervolt <= 1'h0;
        for (int i = 0; i < 6; i++) begin
            r = {$random(seed), $random(seed)};
            {external_switch, temp_level} <= r[2:0];
            node_addr <= r[14:8];
            repeat (4) @(posedge clk_sys);
            stat({3'h0, 1'(i == 0), 2'h0, temp_level});
        end
        prep(node_addr ^ 7'h01);
        check(16'(trim_prepared), 16'h0000);
        prep(node_addr);
        check(16'(trim_prepared), 16'h0001);
        addr_pin_state <= 3'h5;
        repeat (4) @(posedge clk_sys);
        mns_lin_master_i.read(6'h3d);
        resp_chk(trim_exp(), 8);
        @(posedge clk_sys);
        check(16'(trim_prepared), 16'h0000);
        mns_lin_master_i.read(6'h3d);
        check(16'(mns_lin_master_i.resp_n), 16'h0000);
        current_location <= r[31:16];
        for (int i = 0; i < 6; i++) begin
            m0 = mv_n;
            h0 = hl_n;
            r = {(i == 5) ? 8'h85 : 8'h84, 1'(i != 2), node_addr ^ 7'(i == 1 || i == 2), 48'h0};
            mns_lin_master_i.send(cmd_id, 2, r, (i == 4) ? 8'h80 : 8'h00, csum(r, 2) ^ 8'(i == 3));
            repeat (2) @(posedge clk_sys);
            check(16'(mv_n - m0), 16'(i == 0 || i == 2));
            check(16'(hl_n - h0), 16'(i == 5));
        end
        check(16'(safe_target_out), 16'(safe_target));
        @(posedge clk_sys);
        check(goal_location, current_location);
        for (int j = 0; j < 6; j++) begin
            m0 = mv_n;
            {sleep_request, init_done, bus_lost} <= 3'(1 << (j % 3));
            safe_move_suppress <= j > 2;
            @(posedge clk_sys);
            {sleep_request, init_done, bus_lost} <= 3'h0;
            repeat (3) @(posedge clk_sys);
            check(16'(mv_n - m0), 16'(j < 3));
        end
        h0 = hl_n;
        {motor_moving, coil_fault} <= 2'h3;
        current_location <= ~current_location;
        repeat (6) @(posedge clk_sys);
        check(16'({hl_n - h0 == 1, shutdown_mode, missed_step_flag, coil_fault_flag}), 16'h000f);
        {goal_load, goal_value} <= {1'h1, 16'h5a5a};
        @(posedge clk_sys);
        goal_load <= 1'h0;
        @(posedge clk_sys);
        check(goal_location, 16'h5a5a);
        stat({3'h3, 3'h0, temp_level});
        {motor_moving, coil_fault} <= 2'h0;
        repeat (3) @(posedge clk_sys);
        check(goal_location, current_location);
        complete_run;
    end
endmodule // tb
bind mns_cmd_node mns_cmd_node_properties #(.TARGET_W(TARGET_W), .POS_W(POS_W)) mns_cmd_node_properties_i (.*);
`default_nettype wire
